// >>> src/clcd_regs.vh
// Constants for the character display instruction decoder.
// Assumes a 20 MHz system clock and a 270 kHz nominal internal oscillator.
`ifndef CLCD_REGS_VH
`define CLCD_REGS_VH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
`define CLCD_SYS_KHZ 20000
`define CLCD_OSC_KHZ 270
`define CLCD_OSC_DIV (`CLCD_SYS_KHZ / `CLCD_OSC_KHZ)

// ----------------------------------------------------------------
// Execution times in ns, and counts in oscillator ticks (round up)
// ----------------------------------------------------------------
`define CLCD_T_CLEAR_NS 1530000
`define CLCD_T_SHORT_NS 39000
`define CLCD_T_DATA_NS 43000
`define CLCD_TICKS(ns) (((ns) * `CLCD_OSC_KHZ + 999999) / 1000000)
`define CLCD_N_CLEAR `CLCD_TICKS(`CLCD_T_CLEAR_NS)
`define CLCD_N_SHORT `CLCD_TICKS(`CLCD_T_SHORT_NS)
`define CLCD_N_DATA `CLCD_TICKS(`CLCD_T_DATA_NS)

// ----------------------------------------------------------------
// Codes, field positions and reset values
// ----------------------------------------------------------------
`define CLCD_SPACE_CODE 8'h20
`define CLCD_HOME_ADDR 7'h00
`define CLCD_BIT_BUSY 7
`define CLCD_BIT_DL 4
`define CLCD_BIT_LINES 3
`define CLCD_BIT_FONT 2
`define CLCD_BIT_SC 3
`define CLCD_BIT_RL 2
`define CLCD_RST_BUS_WIDTH 1'b1
`define CLCD_RST_INCREMENT 1'b1

`endif

// >>> src/clcd_pipe_buffer.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the drain side may stall freely.
`timescale 1ns/10ps
module clcd_pipe_buffer #(
	parameter WIDTH = 10
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Fill side
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	// Drain side
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] slot0;
	reg [WIDTH-1:0] slot1;
	reg [1:0] count;
	wire push;
	wire pop;

	assign o_in_ready = (count != 2'h2);
	assign o_out_valid = (count != 2'h0);
	assign o_out_data = slot0;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			count <= 2'h0;
			slot0 <= {WIDTH{1'b0}};
			slot1 <= {WIDTH{1'b0}};
		end else begin
			// Head shifts forward on pop
			if (pop) begin
				slot0 <= (count == 2'h2) ? slot1 : i_in_data;
			end else if (push && count == 2'h0) begin
				slot0 <= i_in_data;
			end
			if (push && ((count == 2'h1 && !pop) || count == 2'h2)) begin
				slot1 <= i_in_data;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // clcd_pipe_buffer

// >>> src/clcd_decoder.v
// Instruction decoder and executor of a character display controller.
// Assumes host pins arrive asynchronously; one 20 MHz clock inside.
`timescale 1ns/10ps
`include "clcd_regs.vh"

module clcd_decoder #(
	parameter OSC_DIV = `CLCD_OSC_DIV,
	parameter CLEAR_TICKS = `CLCD_N_CLEAR,
	parameter SHORT_TICKS = `CLCD_N_SHORT,
	parameter DATA_TICKS = `CLCD_N_DATA
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Host port pins
	input wire i_register_select,
	input wire i_read_write,
	input wire i_enable,
	input wire [7:0] i_host_data_lines,
	output reg [7:0] o_host_data_lines,
	output wire o_host_data_oe,
	// Status
	output wire o_busy_flag,
	output wire o_latch_ready,
	output wire [6:0] o_address_counter,
	// Settings
	output reg o_bus_width_select,
	output reg o_line_count,
	output reg o_font_select,
	output reg o_entry_increment,
	output reg o_auto_display_move,
	output reg o_display_enable,
	output reg o_cursor_enable,
	output reg o_blink_enable,
	output reg o_glyph_select,
	output reg [6:0] o_display_shift,
	// Panel scan port
	input wire [6:0] i_scan_addr,
	output reg [7:0] o_scan_char
);
	// ----------------------------------------------------------------
	// States and storage
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_FILL = 3'h2;
	localparam [2:0] ST_WAIT = 3'h4;

	reg [7:0] display_ram [0:127];
	reg [7:0] glyph_ram [0:63];

	reg [2:0] state;
	reg [6:0] address_counter;
	reg [6:0] fill_addr;
	reg [8:0] wait_count;
	reg [6:0] osc_div;
	reg osc_tick;

	function [6:0] clcd_step;
		input [6:0] addr;
		input up;
		begin
			clcd_step = up ? addr + 7'h01 : addr - 7'h01;
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [10:0] pin_meta;
	reg [10:0] pin_sync;
	reg enable_last;
	wire rs_s;
	wire rw_s;
	wire en_s;
	wire [7:0] data_s;
	wire en_rise;
	wire en_fall;

	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			pin_meta <= 11'h000;
			pin_sync <= 11'h000;
			enable_last <= 1'b0;
		end else begin
			pin_meta <= {i_register_select, i_read_write, i_enable, i_host_data_lines};
			pin_sync <= pin_meta;
			enable_last <= pin_sync[8];
		end
	end

	assign rs_s = pin_sync[10];
	assign rw_s = pin_sync[9];
	assign en_s = pin_sync[8];
	assign data_s = pin_sync[7:0];
	assign en_rise = en_s & ~enable_last;
	assign en_fall = ~en_s & enable_last;

	// ----------------------------------------------------------------
	// Host transfer capture
	// ----------------------------------------------------------------
	reg hold_rs;
	reg hold_rw;
	reg [7:0] hold_data;
	reg nibble_phase;
	reg [3:0] high_nibble;
	reg [7:0] read_byte;
	wire [7:0] full_byte;
	wire byte_done;
	wire push_valid;
	wire push_ready;
	wire [9:0] push_data;

	// Last values seen while enable is high stand in for the fall
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			hold_rs <= 1'b0;
			hold_rw <= 1'b0;
			hold_data <= 8'h00;
		end else if (en_s) begin
			hold_rs <= rs_s;
			hold_rw <= rw_s;
			hold_data <= data_s;
		end
	end

	assign full_byte = o_bus_width_select ? hold_data : {high_nibble, hold_data[7:4]};
	assign byte_done = en_fall & (o_bus_width_select | nibble_phase);
	// Status reads need no execution, so they never enter the buffer
	assign push_valid = byte_done & (hold_rs | ~hold_rw);
	assign push_data = {hold_rw, hold_rs, full_byte};

	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			nibble_phase <= 1'b0;
			high_nibble <= 4'h0;
		end else if (en_fall) begin
			nibble_phase <= o_bus_width_select ? 1'b0 : ~nibble_phase;
			high_nibble <= hold_data[7:4];
		end
	end

	// Read word fixed at enable rise; the second nibble reuses it
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			read_byte <= 8'h00;
			o_host_data_lines <= 8'h00;
		end else if (en_rise && rw_s) begin
			if (!nibble_phase || o_bus_width_select) begin
				if (rs_s) begin
					read_byte <= o_glyph_select ? glyph_ram[address_counter[5:0]]
						: display_ram[address_counter];
					o_host_data_lines <= o_glyph_select ? glyph_ram[address_counter[5:0]]
						: display_ram[address_counter];
				end else begin
					read_byte <= {o_busy_flag, address_counter};
					o_host_data_lines <= {o_busy_flag, address_counter};
				end
			end else begin
				o_host_data_lines <= {read_byte[3:0], 4'h0};
			end
		end
	end

	assign o_host_data_oe = en_s & rw_s;

	// ----------------------------------------------------------------
	// Instruction buffer
	// ----------------------------------------------------------------
	wire cmd_valid;
	wire [9:0] cmd;
	wire cmd_take;

	// A host that ignores busy can fill both slots; a third byte is lost
	clcd_pipe_buffer #(
		.WIDTH(10)
	) u_buffer (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(push_valid),
		.o_in_ready(push_ready),
		.i_in_data(push_data),
		.o_out_valid(cmd_valid),
		.i_out_ready(cmd_take),
		.o_out_data(cmd)
	);

	assign o_latch_ready = push_ready;
	assign cmd_take = (state == ST_IDLE);
	assign o_busy_flag = (state != ST_IDLE) | cmd_valid;
	assign o_address_counter = address_counter;

	// ----------------------------------------------------------------
	// Oscillator tick
	// ----------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			osc_div <= 7'h00;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= (osc_div == 7'h00);
			osc_div <= (osc_div == 7'h00) ? OSC_DIV[6:0] - 7'h01 : osc_div - 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// RAM writes
	// ----------------------------------------------------------------
	wire dispatch;
	wire is_write;
	wire is_read;
	wire [7:0] op;

	assign dispatch = cmd_valid & cmd_take;
	assign is_write = dispatch & cmd[8] & ~cmd[9];
	assign is_read = dispatch & cmd[8] & cmd[9];
	assign op = cmd[7:0];

	always @(posedge i_sys_clk) begin
		if (state == ST_FILL) begin
			display_ram[fill_addr] <= `CLCD_SPACE_CODE;
		end else if (is_write && !o_glyph_select) begin
			display_ram[address_counter] <= op;
		end
		if (is_write && o_glyph_select) begin
			glyph_ram[address_counter[5:0]] <= op;
		end
	end

	// ----------------------------------------------------------------
	// Executor
	// ----------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			address_counter <= `CLCD_HOME_ADDR;
			fill_addr <= 7'h00;
			wait_count <= 9'h000;
			o_bus_width_select <= `CLCD_RST_BUS_WIDTH;
			o_line_count <= 1'b0;
			o_font_select <= 1'b0;
			o_entry_increment <= `CLCD_RST_INCREMENT;
			o_auto_display_move <= 1'b0;
			o_display_enable <= 1'b0;
			o_cursor_enable <= 1'b0;
			o_blink_enable <= 1'b0;
			o_glyph_select <= 1'b0;
			o_display_shift <= 7'h00;
		end else begin
			case (state)
			ST_IDLE: begin
				if (dispatch) begin
					state <= ST_WAIT;
					wait_count <= SHORT_TICKS[8:0];
					if (cmd[8]) begin
						wait_count <= DATA_TICKS[8:0];
						address_counter <= clcd_step(address_counter, o_entry_increment);
						if (is_write && !o_glyph_select && o_auto_display_move) begin
							o_display_shift <= clcd_step(o_display_shift, o_entry_increment);
						end
					end else if (op[7]) begin
						address_counter <= op[6:0];
						o_glyph_select <= 1'b0;
					end else if (op[6]) begin
						address_counter <= {1'b0, op[5:0]};
						o_glyph_select <= 1'b1;
					end else if (op[5]) begin
						o_bus_width_select <= op[`CLCD_BIT_DL];
						o_line_count <= op[`CLCD_BIT_LINES];
						o_font_select <= op[`CLCD_BIT_FONT];
					end else if (op[4]) begin
						// Display offset grows toward a left shift
						if (op[`CLCD_BIT_SC]) begin
							o_display_shift <= clcd_step(o_display_shift, ~op[`CLCD_BIT_RL]);
						end else begin
							address_counter <= clcd_step(address_counter, op[`CLCD_BIT_RL]);
						end
					end else if (op[3]) begin
						o_display_enable <= op[2];
						o_cursor_enable <= op[1];
						o_blink_enable <= op[0];
					end else if (op[2]) begin
						o_entry_increment <= op[1];
						o_auto_display_move <= op[0];
					end else if (op[1]) begin
						wait_count <= CLEAR_TICKS[8:0];
						address_counter <= `CLCD_HOME_ADDR;
						o_display_shift <= 7'h00;
						o_glyph_select <= 1'b0;
					end else if (op[0]) begin
						state <= ST_FILL;
						fill_addr <= 7'h00;
						wait_count <= CLEAR_TICKS[8:0];
						address_counter <= `CLCD_HOME_ADDR;
						o_display_shift <= 7'h00;
						o_entry_increment <= 1'b1;
						o_glyph_select <= 1'b0;
					end else begin
						state <= ST_IDLE;
					end
				end
			end
			ST_FILL: begin
				// Fill runs far shorter than the clear time, so it overlaps it
				fill_addr <= fill_addr + 7'h01;
				if (osc_tick && wait_count != 9'h000) begin
					wait_count <= wait_count - 9'h001;
				end
				if (fill_addr == 7'h7F) begin
					state <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_count == 9'h000) begin
					state <= ST_IDLE;
				end else if (osc_tick) begin
					wait_count <= wait_count - 9'h001;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Panel scan
	// ----------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_scan_char <= `CLCD_SPACE_CODE;
		end else begin
			// Blanking shows spaces; RAM itself is left intact
			o_scan_char <= o_display_enable ? display_ram[i_scan_addr]
				: `CLCD_SPACE_CODE;
		end
	end
endmodule // clcd_decoder

// >>> sim/clcd_decoder_checker.sv
// Checker: port relations of the instruction decoder.
// Assumes a bind onto clcd_decoder with its simulation tick counts.
`timescale 1ns/10ps
module clcd_decoder_checker #(
	parameter OSC_DIV = 2,
	parameter SHORT_TICKS = 3
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	// Host pins
	input wire i_read_write,
	input wire i_enable,
	input wire o_host_data_oe,
	// Status and settings
	input wire o_busy_flag,
	input wire o_latch_ready,
	input wire [6:0] o_address_counter,
	input wire o_entry_increment,
	input wire o_display_enable,
	input wire [6:0] o_display_shift,
	input wire [7:0] o_scan_char
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	logic [11:0] busy_len;
	always @(posedge i_sys_clk) begin
		if (!i_reset_n || !o_busy_flag)
			busy_len <= 12'h000;
		else
			busy_len <= busy_len + 12'h001;
	end
	// Two sync flops: pins reach the outputs two edges late
	sequence s_rd_rise;
		$rose(i_enable) && i_read_write;
	endsequence
	sequence s_rd_hold;
		(i_enable && i_read_write) [*3];
	endsequence
	a_oe_on_read: assert property (s_rd_rise ##0 s_rd_hold |-> o_host_data_oe)
		else $error("read strobe without bus drive");
	a_oe_no_write: assert property (!i_read_write [*3] |-> !o_host_data_oe)
		else $error("bus driven during a write");
	a_busy_min: assert property ($fell(o_busy_flag)
		|-> $past(busy_len) >= (SHORT_TICKS - 1) * OSC_DIV) else $error("busy too short");
	a_busy_max: assert property ($rose(o_busy_flag) |-> ##[1:1000] !o_busy_flag)
		else $error("busy never drops");
	a_full_busy: assert property (!o_latch_ready |-> o_busy_flag)
		else $error("full buffer while idle");
	a_ac_quiet: assert property ($changed(o_address_counter)
		|-> o_busy_flag || $past(o_busy_flag)) else $error("counter moved while idle");
	a_entry_quiet: assert property ($changed(o_entry_increment) |-> $past(o_busy_flag))
		else $error("entry mode moved while idle");
	a_shift_unit: assert property ($changed(o_display_shift) |-> o_display_shift == 7'h00
		|| 7'(o_display_shift - $past(o_display_shift)) inside {7'h01, 7'h7F})
		else $error("display shift not one step");
	a_blank_scan: assert property (!$past(o_display_enable) |-> o_scan_char == 8'h20)
		else $error("blanked panel shows data");
endmodule // clcd_decoder_checker

bind clcd_decoder clcd_decoder_checker #(.OSC_DIV(OSC_DIV), .SHORT_TICKS(SHORT_TICKS)) i_checker (
	.i_sys_clk, .i_reset_n, .i_read_write, .i_enable, .o_host_data_oe, .o_busy_flag,
	.o_latch_ready, .o_address_counter, .o_entry_increment, .o_display_enable,
	.o_display_shift, .o_scan_char
);

// >>> sim/clcd_host_model.sv
// Host model: strobes the parallel port like a microprocessor.
// Assumes the decoder synchronises the pins to its own clock.
`timescale 1ns/10ps
module clcd_host_model (
	// Clock
	input wire i_sys_clk,
	// Port pins
	output logic o_rs,
	output logic o_rw,
	output logic o_en,
	output logic [7:0] o_data,
	input wire [7:0] i_data,
	input wire i_busy
);
	// ----------------------------------------------------------------
	// Transfers
	// ----------------------------------------------------------------
	initial begin
		o_rs = 1'b0;
		o_rw = 1'b0;
		o_en = 1'b0;
		o_data = 8'h00;
	end
	// Strobe held 6 cycles, pins 4 more after the fall; released data inverts
	task automatic xfer(input logic rs, rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge i_sys_clk) #5;
		o_rs = rs;
		o_rw = rw;
		o_data = rw ? ~o_data : d;
		@(posedge i_sys_clk) #5;
		o_en = 1'b1;
		repeat (6) @(posedge i_sys_clk);
		#5;
		q = i_data;
		o_en = 1'b0;
		repeat (4) @(posedge i_sys_clk);
		#5;
		o_data = ~o_data;
	endtask
	// Poll busy, then two clock cycles of margin
	task automatic wait_idle(output int n);
		n = 0;
		while (i_busy !== 1'b0 && n < 3000) begin
			@(posedge i_sys_clk) #5;
			n++;
		end
		repeat (2) @(posedge i_sys_clk);
	endtask
endmodule // clcd_host_model

// >>> sim/tb.sv
// Testbench: host model against the decoder, scan port read back.
// Assumes short tick counts: OSC_DIV 2, clear 200, short 3, data 4.
`timescale 1ns/10ps
module tb;
	localparam int OSC = 2;
	localparam int CLR = 200;
	logic i_sys_clk;
	logic i_reset_n;
	logic [6:0] i_scan_addr;
	logic [7:0] q;
	wire i_register_select, i_read_write, i_enable, o_host_data_oe, o_busy_flag, o_latch_ready;
	wire o_bus_width_select, o_line_count, o_font_select, o_entry_increment, o_auto_display_move;
	wire o_display_enable, o_cursor_enable, o_blink_enable, o_glyph_select;
	wire [7:0] host_out, i_host_data_lines, o_host_data_lines, o_scan_char;
	wire [6:0] o_address_counter, o_display_shift;
	int bad_count;
	int num_checks;
	int cycles;
	int n;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	assign i_host_data_lines = o_host_data_oe ? o_host_data_lines : host_out;
	clcd_decoder #(.OSC_DIV(OSC), .CLEAR_TICKS(CLR), .SHORT_TICKS(3), .DATA_TICKS(4)) i_dut (
		.i_sys_clk, .i_reset_n, .i_register_select, .i_read_write, .i_enable,
		.i_host_data_lines, .o_host_data_lines, .o_host_data_oe, .o_busy_flag, .o_latch_ready,
		.o_address_counter, .o_bus_width_select, .o_line_count, .o_font_select,
		.o_entry_increment, .o_auto_display_move, .o_display_enable, .o_cursor_enable,
		.o_blink_enable, .o_glyph_select, .o_display_shift, .i_scan_addr, .o_scan_char
	);
	clcd_host_model i_host (.i_sys_clk, .o_rs(i_register_select), .o_rw(i_read_write),
		.o_en(i_enable), .o_data(host_out), .i_data(i_host_data_lines), .i_busy(o_busy_flag));
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [7:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic op(input logic rs, rw, input logic [7:0] d);
		i_host.xfer(rs, rw, d, q);
		i_host.wait_idle(n);
	endtask
	// Four-bit mode: upper lines only, high nibble first
	task automatic op4(input logic rs, rw, input logic [7:0] d);
		logic [7:0] hi;
		i_host.xfer(rs, rw, {d[7:4], 4'h0}, hi);
		i_host.xfer(rs, rw, {d[3:0], 4'h0}, q);
		q = {hi[7:4], q[7:4]};
		i_host.wait_idle(n);
	endtask
	task automatic scan(input logic [6:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk) #5;
		i_scan_addr = a;
		repeat (2) @(posedge i_sys_clk);
		#5;
		chk("scan", exp, o_scan_char);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_settings();
		chk("width", 8'h01, 8'(o_bus_width_select));
		op(1'b0, 1'b0, 8'h3C);
		chk("func", 8'h07, 8'({o_bus_width_select, o_line_count, o_font_select}));
		op(1'b0, 1'b0, 8'h0D);
		chk("ctrl", 8'h05, 8'({o_display_enable, o_cursor_enable, o_blink_enable}));
		op(1'b0, 1'b0, 8'h0E);
		chk("ctrl", 8'h06, 8'({o_display_enable, o_cursor_enable, o_blink_enable}));
		op(1'b0, 1'b0, 8'h05);
		chk("entry", 8'h01, 8'({o_entry_increment, o_auto_display_move}));
		chk("short", 8'h01, 8'(n >= 2 && n <= 7));
	endtask
	task automatic t_clear();
		op(1'b0, 1'b0, 8'h8F);
		op(1'b1, 1'b0, 8'h77);
		op(1'b0, 1'b0, 8'h01);
		chk("clear", 8'h01, 8'(n >= (CLR - 1) * OSC - 4 && n <= CLR * OSC + 4));
		chk("ac", 8'h00, 8'(o_address_counter));
		chk("incr", 8'h01, 8'(o_entry_increment));
		scan(7'h0F, 8'h20);
		scan(7'h7F, 8'h20);
	endtask
	task automatic t_ram();
		op(1'b0, 1'b0, 8'h06);
		op(1'b0, 1'b0, 8'h90);
		chk("ac", 8'h10, 8'(o_address_counter));
		op(1'b1, 1'b0, 8'hA5);
		chk("data", 8'h01, 8'(n >= 4 && n <= 9));
		op(1'b1, 1'b0, 8'h3C);
		chk("ac", 8'h12, 8'(o_address_counter));
		scan(7'h11, 8'h3C);
		op(1'b0, 1'b0, 8'h90);
		op(1'b1, 1'b1, 8'h00);
		chk("rdata", 8'hA5, q);
		chk("ac", 8'h11, 8'(o_address_counter));
		op(1'b0, 1'b0, 8'h04);
		op(1'b0, 1'b0, 8'h85);
		op(1'b1, 1'b0, 8'h11);
		chk("ac", 8'h04, 8'(o_address_counter));
		op(1'b0, 1'b0, 8'h7F);
		chk("glyph", 8'h01, 8'(o_glyph_select));
		op(1'b1, 1'b0, 8'h22);
		chk("ac", 8'h3E, 8'(o_address_counter));
		scan(7'h3F, 8'h20);
		op(1'b0, 1'b0, 8'h7F);
		op(1'b1, 1'b1, 8'h00);
		chk("rdata", 8'h22, q);
	endtask
	task automatic t_shift();
		op(1'b0, 1'b0, 8'h02);
		chk("home", 8'h01, 8'(n >= (CLR - 1) * OSC - 4 && n <= CLR * OSC + 4));
		op(1'b0, 1'b0, 8'h07);
		op(1'b0, 1'b0, 8'h80);
		op(1'b1, 1'b0, 8'h41);
		chk("shift", 8'h01, 8'(o_display_shift));
		op(1'b0, 1'b0, 8'h80);
		op(1'b1, 1'b1, 8'h00);
		chk("shift", 8'h01, 8'(o_display_shift));
		op(1'b0, 1'b0, 8'h05);
		op(1'b1, 1'b0, 8'h42);
		chk("shift", 8'h00, 8'(o_display_shift));
		op(1'b0, 1'b0, 8'h10);
		chk("ac", 8'h7F, 8'(o_address_counter));
		op(1'b0, 1'b0, 8'h14);
		chk("ac", 8'h00, 8'(o_address_counter));
		op(1'b0, 1'b0, 8'h1C);
		chk("shift", 8'h7F, 8'(o_display_shift));
		op(1'b0, 1'b0, 8'h18);
		op(1'b0, 1'b0, 8'h18);
		chk("shift", 8'h01, 8'(o_display_shift));
		chk("ac", 8'h00, 8'(o_address_counter));
		op(1'b0, 1'b0, 8'h02);
		chk("shift", 8'h00, 8'(o_display_shift));
		scan(7'h01, 8'h42);
	endtask
	task automatic t_status();
		i_host.xfer(1'b0, 1'b0, 8'h01, q);
		i_host.xfer(1'b0, 1'b1, 8'h00, q);
		chk("bf", 8'h01, 8'(q[7]));
		i_host.wait_idle(n);
		op(1'b0, 1'b0, 8'h9A);
		op(1'b0, 1'b1, 8'h00);
		chk("status", 8'h1A, q);
		chk("stime", 8'h00, 8'(n));
	endtask
	// Clear runs, two writes fill both entries, the fourth byte is dropped
	task automatic t_buffer();
		i_host.xfer(1'b0, 1'b0, 8'h01, q);
		i_host.xfer(1'b1, 1'b0, 8'h4A, q);
		i_host.xfer(1'b1, 1'b0, 8'h4B, q);
		chk("ready", 8'h00, 8'(o_latch_ready));
		op(1'b1, 1'b0, 8'h4C);
		chk("ac", 8'h02, 8'(o_address_counter));
		scan(7'h00, 8'h4A);
		scan(7'h01, 8'h4B);
		scan(7'h02, 8'h20);
		op(1'b0, 1'b0, 8'h08);
		chk("ctrl", 8'h00, 8'({o_display_enable, o_cursor_enable, o_blink_enable}));
		scan(7'h00, 8'h20);
		op(1'b0, 1'b0, 8'h0C);
		scan(7'h00, 8'h4A);
	endtask
	task automatic t_nibble();
		op(1'b0, 1'b0, 8'h28);
		chk("width", 8'h00, 8'(o_bus_width_select));
		op4(1'b0, 1'b0, 8'h83);
		op4(1'b1, 1'b0, 8'h5A);
		scan(7'h03, 8'h5A);
		op4(1'b0, 1'b0, 8'h83);
		op4(1'b1, 1'b1, 8'h00);
		chk("nibble", 8'h5A, q);
		op4(1'b0, 1'b0, 8'h38);
		chk("width", 8'h01, 8'(o_bus_width_select));
		chk("func", 8'h06, 8'({o_bus_width_select, o_line_count, o_font_select}));
	endtask
	initial begin
		i_reset_n = 1'b0;
		i_scan_addr = 7'h00;
		repeat (10) @(posedge i_sys_clk);
		#5;
		i_reset_n = 1'b1;
		repeat (4) @(posedge i_sys_clk);
		t_settings();
		t_clear();
		t_ram();
		t_shift();
		t_status();
		t_buffer();
		t_nibble();
		wrap_up();
	end
endmodule // tb
